// *** verification/usie_ctrl_assertions.sv ***
// Port-level checks for the control block
`timescale 1ns/1ps
`default_nettype none
module usie_ctrl_chk
   import usie_pkg::*;
(
   input wire logic        clock_i,
   input wire logic        nrst_i,
   input wire logic [11:0] reg_addr_i,
   input wire logic [7:0]  reg_wdata_i,
   input wire logic        reg_wr_i,
   input wire logic        reg_rd_i,
   input wire logic [7:0]  reg_rdata_o,
   input wire logic        sie_setup_tok_i,
   input wire logic        sie_sof_tok_i,
   input wire logic [10:0] sie_frame_i,
   input wire logic        sie_bus_reset_i,
   input wire logic [6:0]  sie_tok_addr_i,
   input wire logic        sie_addr_match_o,
   input wire logic        pingpong_pointer_reset_o,
   input wire logic        packet_transfer_disable_o,
   input wire logic        sie_clk_enable_o,
   input wire logic        suspend_request_o,
   input wire logic        transceiver_enable_o,
   input wire logic        full_speed_select_o,
   input wire logic        onchip_pullup_enable_o,
   input wire logic        frame_valid_o,
   input wire logic [1:0]  pingpong_mode_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!nrst_i);
   ////////////////////////////////////////////////////////////////////////
   sequence s_setup;
      sie_setup_tok_i && transceiver_enable_o;
   endsequence
   sequence s_sof_read;
      sie_sof_tok_i && frame_valid_o ##2
      reg_rd_i && reg_addr_i == USIE_FRML_ADDR;
   endsequence
   a_setup_halts: assert property (s_setup |=> packet_transfer_disable_o)
      else $error("setup token did not disable packets");
   a_never_set: assert property (
      !packet_transfer_disable_o && !sie_setup_tok_i
      |=> !packet_transfer_disable_o)
      else $error("transfer disable set without setup");
   a_frame_load: assert property (
      s_sof_read |=> reg_rdata_o == $past(sie_frame_i[7:0], 3))
      else $error("frame low byte not loaded by start of frame");
   a_addr_cleared: assert property (
      sie_bus_reset_i |=> sie_addr_match_o ==
      (transceiver_enable_o && sie_tok_addr_i == 7'h00))
      else $error("bus reset did not clear device address");
   a_pullup_gate: assert property (
      onchip_pullup_enable_o |-> transceiver_enable_o)
      else $error("pull-up on with transceiver off");
   a_pp_ignored: assert property (
      pingpong_pointer_reset_o |-> pingpong_mode_o != USIE_PPM_NONE)
      else $error("pointer reset active without ping-pong");
   a_susp_gate: assert property (
      reg_wr_i && reg_addr_i == USIE_CTRL_ADDR && reg_wdata_i[USIE_CTRL_SUSP]
      |=> suspend_request_o && !sie_clk_enable_o)
      else $error("suspend did not gate engine clock");
   a_speed_sel: assert property (
      reg_wr_i && reg_addr_i == USIE_CFG_ADDR
      |=> full_speed_select_o == $past(reg_wdata_i[USIE_CFG_FS]))
      else $error("speed select does not follow write");
   a_rdata_once: assert property (
      $changed(reg_rdata_o) && reg_rdata_o != 8'h00 |-> $past(reg_rd_i))
      else $error("read data without a read");
   a_unmapped_zero: assert property (
      reg_rd_i && !(reg_addr_i inside {[12'h060:12'h064], [12'h200:12'h2ff]})
      |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   a_frame_stale: assert property (suspend_request_o |-> !frame_valid_o)
      else $error("frame valid during suspend");
endmodule : usie_ctrl_chk
`default_nettype wire

// *** verification/usie_ctrl_test.sv ***
// Self-checking bench for the control block
`timescale 1ns/1ps
`default_nettype none
module usie_ctrl_test;
   import usie_pkg::*;
   logic clock_i, nrst_i, reg_wr_i, reg_rd_i, sie_addr_match_o;
   logic [11:0] reg_addr_i;
   logic [7:0] reg_wdata_i, reg_rdata_o, sie_ram_addr_i, sie_ram_wdata_i;
   logic [7:0] sie_ram_rdata_o, d, p, m_ctrl, m_cfg, m_addr;
   logic sie_setup_tok_i, sie_sof_tok_i, sie_bus_reset_i, sie_ram_en_i;
   logic [10:0] sie_frame_i, m_frm;
   logic [6:0] sie_tok_addr_i;
   logic sie_ram_we_i, sie_ram_stat_i, sie_tx_en_i, sie_tx_dp_i, sie_tx_dm_i;
   logic [3:0] sie_pid_i;
   logic pingpong_pointer_reset_o, packet_transfer_disable_o, frame_valid_o;
   logic sie_clk_enable_o, suspend_request_o, transceiver_enable_o;
   logic full_speed_select_o, onchip_pullup_enable_o;
   logic usb_dp_o, usb_dm_o, usb_oe_o;
   logic [1:0] pingpong_mode_o;
   logic [7:0] m_ram [256];
   logic [11:0] amap [8] = '{12'h060, 12'h061, 12'h062, 12'h063, 12'h064,
                             12'h065, 12'h1ff, 12'h300};
   int fails = 0, cmp_count = 0, cyc = 0, seed;
   usie_ctrl uut (.*);
   usie_host_model host (.clock_i, .setup_o(sie_setup_tok_i),
      .sof_o(sie_sof_tok_i), .frame_o(sie_frame_i),
      .bus_reset_o(sie_bus_reset_i), .tok_addr_o(sie_tok_addr_i));
   ////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   function automatic logic [7:0] ev(input logic [11:0] a);
      case (a)
         USIE_CTRL_ADDR:  return m_ctrl;
         USIE_CFG_ADDR:   return m_cfg;
         USIE_DADDR_ADDR: return m_addr;
         USIE_FRML_ADDR:  return m_frm[7:0];
         USIE_FRMH_ADDR:  return {5'h00, m_frm[10:8]};
         default:         return a[11:8] == 4'h2 ? m_ram[a[7:0]] : 8'h00;
      endcase
   endfunction : ev
   task automatic wr(input logic [11:0] a, input logic [7:0] w);
      @(posedge clock_i);
      {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, w};
      @(posedge clock_i);
      reg_wr_i <= 1'b0;
      // Firmware can only clear the transfer-disable flag
      if (a == USIE_CTRL_ADDR) m_ctrl = (w & 8'h4e) | (m_ctrl & w & 8'h10);
      if (a == USIE_CFG_ADDR) m_cfg = w & 8'h97;
      if (a == USIE_DADDR_ADDR) m_addr = w & 8'h7f;
      if (a[11:8] == 4'h2) m_ram[a[7:0]] = w;
   endtask : wr
   task automatic rd(input logic [11:0] a);
      @(posedge clock_i);
      {reg_rd_i, reg_addr_i} <= {1'b1, a};
      @(posedge clock_i);
      reg_rd_i <= 1'b0;
      #1 chk(reg_rdata_o, ev(a));
   endtask : rd
   task automatic chk_out();
      logic en;
      en = m_ctrl[3];
      #1 chk({transceiver_enable_o, full_speed_select_o,
              onchip_pullup_enable_o, pingpong_pointer_reset_o,
              packet_transfer_disable_o, suspend_request_o,
              sie_clk_enable_o, frame_valid_o},
             {en, m_cfg[2], m_cfg[4] & en, m_ctrl[6] & (m_cfg[1:0] != 0),
              m_ctrl[4], m_ctrl[1], en & !m_ctrl[1], en & !m_ctrl[1]});
      chk({6'h00, pingpong_mode_o}, {6'h00, m_cfg[1:0]});
   endtask : chk_out
   task automatic tok(input int k, input logic [10:0] f);
      host.send(k, f);
      if (k == 0 && m_ctrl[3]) m_ctrl[4] = 1'b1;
      if (k == 1 && m_ctrl[3] && !m_ctrl[1]) m_frm = f;
      if (k == 2) m_addr = 8'h00;
   endtask : tok
   task automatic eng(input logic w, s, input logic [7:0] a, v,
                      input logic [3:0] id);
      @(posedge clock_i);
      {sie_ram_en_i, sie_ram_we_i, sie_ram_stat_i} <= {1'b1, w, s};
      {sie_ram_addr_i, sie_ram_wdata_i, sie_pid_i} <= {a, v, id};
      @(posedge clock_i);
      {sie_ram_en_i, sie_ram_we_i} <= 2'b00;
      #1 if (!w) chk(sie_ram_rdata_o, m_ram[a]);
      if (w && s && a <= USIE_DESC_LAST) m_ram[a] = {v[7:6], id, v[1:0]};
      else if (w) m_ram[a] = v;
   endtask : eng
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clock_i = 1'b0;
      forever #4 clock_i = ~clock_i;
   end
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         give_verdict();
      end
   end
   initial begin
      {nrst_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
      {sie_ram_en_i, sie_ram_we_i, sie_ram_stat_i, sie_pid_i} = '0;
      {sie_ram_addr_i, sie_ram_wdata_i} = '0;
      {sie_tx_en_i, sie_tx_dp_i, sie_tx_dm_i} = '0;
      {m_ctrl, m_cfg, m_addr, m_frm} = '0;
      seed = $urandom(32'hcfe18999);
      repeat (2) @(posedge clock_i);
      nrst_i <= 1'b1;
      foreach (amap[i]) rd(amap[i]);
      chk_out();
      $display("test 1 done");
      repeat (6) begin
         wr(USIE_CTRL_ADDR, 8'($urandom));
         wr(USIE_CFG_ADDR, 8'($urandom));
         chk_out();
         rd(USIE_CTRL_ADDR);
         rd(USIE_CFG_ADDR);
      end
      wr(USIE_CFG_ADDR, 8'h01);
      wr(USIE_CTRL_ADDR, 8'h00);
      tok(0, 11'h000);
      rd(USIE_CTRL_ADDR);
      wr(USIE_CTRL_ADDR, 8'h48);
      tok(0, 11'h000);
      chk_out();
      wr(USIE_CTRL_ADDR, 8'h18);
      rd(USIE_CTRL_ADDR);
      wr(USIE_CTRL_ADDR, 8'h08);
      rd(USIE_CTRL_ADDR);
      $display("test 2 done");
      d = 8'($urandom);
      wr(USIE_DADDR_ADDR, d);
      host.aim(d[6:0]);
      #1 chk({7'h00, sie_addr_match_o}, 8'h01);
      tok(2, 11'h000);
      rd(USIE_DADDR_ADDR);
      host.aim(7'h00);
      #1 chk({7'h00, sie_addr_match_o}, 8'h01);
      $display("test 3 done");
      repeat (3) begin
         tok(1, 11'($urandom));
         rd(USIE_FRML_ADDR);
         rd(USIE_FRMH_ADDR);
      end
      wr(USIE_FRML_ADDR, 8'hff);
      wr(USIE_FRMH_ADDR, 8'hff);
      rd(USIE_FRML_ADDR);
      @(posedge clock_i);
      {sie_tx_en_i, sie_tx_dp_i} <= 2'b11;
      // Idle detect lives outside; suspend is forced here
      wr(USIE_CTRL_ADDR, 8'h0a);
      tok(1, 11'h7ff);
      rd(USIE_FRMH_ADDR);
      chk_out();
      chk({7'h00, usb_oe_o}, 8'h00);
      // Resume held a few cycles only; the long hold is software's
      wr(USIE_CTRL_ADDR, 8'h0e);
      repeat (2) @(posedge clock_i);
      #1 chk({5'h00, usb_oe_o, usb_dp_o, usb_dm_o},
             {5'h00, 1'b1, ~m_cfg[2], m_cfg[2]});
      wr(USIE_CTRL_ADDR, 8'h08);
      wr(USIE_CFG_ADDR, 8'h84);
      repeat (2) @(posedge clock_i);
      #1 p = {6'h00, usb_oe_o, usb_dp_o};
      chk({7'h00, usb_dp_o ^ usb_dm_o}, 8'h01);
      @(posedge clock_i);
      #1 chk({6'h00, usb_oe_o, usb_dp_o ^ p[0]}, 8'h03);
      tok(0, 11'h000);
      wr(USIE_CFG_ADDR, 8'h04);
      repeat (2) @(posedge clock_i);
      #1 chk({7'h00, usb_oe_o}, 8'h00);
      wr(USIE_CTRL_ADDR, 8'h08);
      repeat (2) @(posedge clock_i);
      #1 chk({5'h00, usb_oe_o, usb_dp_o, usb_dm_o}, 8'h06);
      $display("test 4 done");
      foreach (amap[i]) begin
         d = i[0] ? 8'($urandom) : {i[2:1], 6'h3f};
         wr({4'h2, d}, 8'($urandom));
         rd({4'h2, d});
      end
      eng(1'b1, 1'b1, 8'h10, 8'($urandom), 4'($urandom));
      rd(12'h210);
      eng(1'b1, 1'b1, 8'h90, 8'($urandom), 4'hf);
      eng(1'b0, 1'b0, 8'h90, 8'h00, 4'h0);
      rd(12'h290);
      $display("test 5 done");
      give_verdict();
   end
endmodule : usie_ctrl_test
bind usie_ctrl usie_ctrl_chk chk (.clock_i, .nrst_i, .reg_addr_i,
   .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .sie_setup_tok_i,
   .sie_sof_tok_i, .sie_frame_i, .sie_bus_reset_i, .sie_tok_addr_i,
   .sie_addr_match_o, .pingpong_pointer_reset_o, .packet_transfer_disable_o,
   .sie_clk_enable_o, .suspend_request_o, .transceiver_enable_o,
   .full_speed_select_o, .onchip_pullup_enable_o, .frame_valid_o,
   .pingpong_mode_o);
`default_nettype wire

// *** verification/usie_host_model.sv ***
// Host-side partner: token events toward the engine inputs
`timescale 1ns/1ps
`default_nettype none
module usie_host_model (
   input  wire logic        clock_i,
   output logic             setup_o,
   output logic             sof_o,
   output logic      [10:0] frame_o,
   output logic             bus_reset_o,
   output logic      [6:0]  tok_addr_o
);
   initial begin
      {setup_o, sof_o, bus_reset_o} = 3'b000;
      frame_o = 11'h555;
      tok_addr_o = 7'h00;
   end
   // Kind 0 setup, 1 start of frame, 2 bus reset
   task automatic send(input int k, input logic [10:0] f);
      @(posedge clock_i);
      setup_o <= (k == 0);
      sof_o <= (k == 1);
      bus_reset_o <= (k == 2);
      frame_o <= f;
      @(posedge clock_i);
      {setup_o, sof_o, bus_reset_o} <= 3'b000;
      // Released frame bus flips so a stale value is never trusted
      frame_o <= ~f;
   endtask : send
   task automatic aim(input logic [6:0] a);
      @(posedge clock_i);
      tok_addr_o <= a;
   endtask : aim
endmodule : usie_host_model
`default_nettype wire

// *** verilog/usie_buf_ram.sv ***
// 256-byte dual-access buffer memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module usie_buf_ram
   import usie_pkg::*;
(
   input  wire logic clock_i,
   input  wire logic nrst_i,
   usie_ram_if.mem   ram
);
   typedef struct packed {
      logic [7:0] cpu_rdata;
      logic [7:0] sie_rdata;
   } usie_ram_s;

   logic [7:0] mem_q [256];
   usie_ram_s  st_ff;
   usie_ram_s  nxt_st;

   always_comb begin
      nxt_st = st_ff;
      if (ram.cpu_en) begin
         nxt_st.cpu_rdata = mem_q[ram.cpu_addr];
      end
      if (ram.sie_en) begin
         nxt_st.sie_rdata = mem_q[ram.sie_addr];
      end
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Engine write goes last so it wins a same-address collision
   always_ff @(posedge clock_i) begin
      if (ram.cpu_en && ram.cpu_we) begin
         mem_q[ram.cpu_addr] <= ram.cpu_wdata;
      end
      if (ram.sie_en && ram.sie_we) begin
         mem_q[ram.sie_addr] <= ram.sie_wdata;
      end
   end

   assign ram.cpu_rdata = st_ff.cpu_rdata;
   assign ram.sie_rdata = st_ff.sie_rdata;
endmodule : usie_buf_ram
`default_nettype wire

// *** verilog/usie_ctrl.sv ***
// Control, configuration, address, frame number and buffer memory top
// What this block does
// - Pointer reset forces all ping-pong pointers even
// - Only firmware clears pointer reset; ignored without ping-pong
// - Setup token sets transfer disable, halting packets
// - Processor may only clear transfer disable
// - Pending completion events stay queued while disabled
// - Resume bit drives resume signalling on bus
// - Suspend enters low power, gates engine clock
// - Suspended device stays attached, line outputs idle unless resume bit set
// - Eye-pattern bit generates eye pattern on bus
// - Module enable also enables internal transceiver
// - Full-speed bit selects full or low speed
// - Pull-up enable works only with transceiver on
// - Bus reset or processor reset clears address
// - Tokens decoded against held device address
// - Eleven-bit frame number split low/high bytes
// - Frame number updated per SOF, read-only
// - Frame number valid only while engine clock runs
// - 256-byte shared buffer memory at 200h-2FFh
// - 200h-27Fh hold endpoint buffer descriptors
// - Engine returns packet identifier in status bits 5-2
`timescale 1ns/1ps
`default_nettype none
module usie_ctrl
   import usie_pkg::*;
(
   input  wire logic        clock_i,
   input  wire logic        nrst_i,
   // Processor register and buffer memory port
   input  wire logic [11:0] reg_addr_i,
   input  wire logic [7:0]  reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [7:0]  reg_rdata_o,
   // Engine token events
   input  wire logic        sie_setup_tok_i,
   input  wire logic        sie_sof_tok_i,
   input  wire logic [10:0] sie_frame_i,
   input  wire logic        sie_bus_reset_i,
   input  wire logic [6:0]  sie_tok_addr_i,
   output logic             sie_addr_match_o,
   // Engine buffer memory port
   input  wire logic        sie_ram_en_i,
   input  wire logic        sie_ram_we_i,
   input  wire logic        sie_ram_stat_i,
   input  wire logic [3:0]  sie_pid_i,
   input  wire logic [7:0]  sie_ram_addr_i,
   input  wire logic [7:0]  sie_ram_wdata_i,
   output logic      [7:0]  sie_ram_rdata_o,
   // Engine transmit request
   input  wire logic        sie_tx_en_i,
   input  wire logic        sie_tx_dp_i,
   input  wire logic        sie_tx_dm_i,
   // Control outputs
   output logic             pingpong_pointer_reset_o,
   output logic             packet_transfer_disable_o,
   output logic             sie_clk_enable_o,
   output logic             suspend_request_o,
   output logic             transceiver_enable_o,
   output logic             full_speed_select_o,
   output logic             onchip_pullup_enable_o,
   output logic             frame_valid_o,
   output logic      [1:0]  pingpong_mode_o,
   // Line driver
   output logic             usb_dp_o,
   output logic             usb_dm_o,
   output logic             usb_oe_o
);

   ////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      logic [7:0]  ctrl;
      logic [7:0]  cfg;
      logic [6:0]  dev_addr;
      logic [10:0] frame;
      logic [7:0]  rdata;
      logic        ram_rd;
      logic        eye_phase;
      logic        dp;
      logic        dm;
      logic        oe;
   } usie_state_s;

   usie_state_s st_ff;
   usie_state_s nxt_st;
   usie_line_e  line_mode;
   logic        cpu_ram_hit;
   logic        moden;
   logic        susp;
   logic        fs;
   logic        j_dp;

   usie_ram_if ram_bus ();

   usie_buf_ram u_ram (
      .clock_i (clock_i),
      .nrst_i  (nrst_i),
      .ram     (ram_bus.mem)
   );

   assign moden = st_ff.ctrl[USIE_CTRL_MODEN];
   assign susp  = st_ff.ctrl[USIE_CTRL_SUSP];
   assign fs    = st_ff.cfg[USIE_CFG_FS];
   // Idle J level: D+ high at full speed, D- high at low speed
   assign j_dp  = fs;

   ////////////////////////////////////////////////////////////////////////
   // Buffer memory access paths
   assign cpu_ram_hit = (reg_addr_i >= USIE_RAM_FIRST) &&
                        (reg_addr_i <= USIE_RAM_LAST);

   // Processor access is not blocked by ownership; firmware must honour
   // the owner bit, the memory only settles write collisions
   assign ram_bus.cpu_en    = cpu_ram_hit && (reg_wr_i || reg_rd_i);
   assign ram_bus.cpu_we    = reg_wr_i;
   assign ram_bus.cpu_addr  = reg_addr_i[7:0];
   assign ram_bus.cpu_wdata = reg_wdata_i;

   assign ram_bus.sie_en    = sie_ram_en_i;
   assign ram_bus.sie_we    = sie_ram_we_i;
   assign ram_bus.sie_addr  = sie_ram_addr_i;

   // Status write-back inside the descriptor region keeps the owner bit
   // as given and returns the packet identifier in bits 5..2
   always_comb begin
      ram_bus.sie_wdata = sie_ram_wdata_i;
      if (sie_ram_stat_i && (sie_ram_addr_i <= USIE_DESC_LAST)) begin
         ram_bus.sie_wdata[USIE_DESC_PID_LO +: 4] = sie_pid_i;
      end
   end
   assign sie_ram_rdata_o = ram_bus.sie_rdata;

   ////////////////////////////////////////////////////////////////////////
   // Line mode select
   always_comb begin
      if (!moden) begin
         line_mode = USIE_LINE_IDLE;
      end else if (st_ff.ctrl[USIE_CTRL_RESUME]) begin
         line_mode = USIE_LINE_RESUME;
      end else if (susp) begin
         line_mode = USIE_LINE_IDLE;
      end else if (st_ff.cfg[USIE_CFG_EYE]) begin
         line_mode = USIE_LINE_EYE;
      end else if (st_ff.ctrl[USIE_CTRL_PACKET_TRANSFER_DISABLE]) begin
         line_mode = USIE_LINE_IDLE;
      end else begin
         line_mode = USIE_LINE_PASS;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      nxt_st = st_ff;

      // Register writes
      if (reg_wr_i) begin
         case (reg_addr_i)
            USIE_CTRL_ADDR: begin
               nxt_st.ctrl = reg_wdata_i & USIE_CTRL_WMASK;
               // Pointer reset is held until firmware writes it to zero
               nxt_st.ctrl[USIE_CTRL_PPRST] =
                  reg_wdata_i[USIE_CTRL_PPRST];
               // Writes may only clear the disable flag
               nxt_st.ctrl[USIE_CTRL_PACKET_TRANSFER_DISABLE] =
                  st_ff.ctrl[USIE_CTRL_PACKET_TRANSFER_DISABLE] &
                  reg_wdata_i[USIE_CTRL_PACKET_TRANSFER_DISABLE];
            end
            USIE_CFG_ADDR: begin
               nxt_st.cfg = reg_wdata_i & USIE_CFG_WMASK;
            end
            USIE_DADDR_ADDR: begin
               nxt_st.dev_addr = reg_wdata_i[6:0];
            end
            default: begin
               nxt_st.dev_addr = st_ff.dev_addr;
            end
         endcase
      end

      // Hardware set wins over a clearing write in the same cycle
      if (sie_setup_tok_i && moden) begin
         nxt_st.ctrl[USIE_CTRL_PACKET_TRANSFER_DISABLE] = 1'b1;
      end
      if (sie_bus_reset_i) begin
         nxt_st.dev_addr = USIE_DADDR_RST;
      end
      // SOF tokens are not seen while the engine clock is gated
      if (sie_sof_tok_i && moden && !susp) begin
         nxt_st.frame = sie_frame_i;
      end

      // Register reads, answered in the next cycle
      nxt_st.ram_rd = reg_rd_i && cpu_ram_hit;
      nxt_st.rdata  = 8'h00;
      if (reg_rd_i) begin
         case (reg_addr_i)
            USIE_CTRL_ADDR: begin
               nxt_st.rdata = st_ff.ctrl;
            end
            USIE_CFG_ADDR: begin
               nxt_st.rdata = st_ff.cfg;
            end
            USIE_DADDR_ADDR: begin
               nxt_st.rdata = {1'b0, st_ff.dev_addr};
            end
            USIE_FRML_ADDR: begin
               nxt_st.rdata = st_ff.frame[7:0];
            end
            USIE_FRMH_ADDR: begin
               // No latching across the pair; software rereads on rollover
               nxt_st.rdata = {5'h00, st_ff.frame[10:8]};
            end
            default: begin
               nxt_st.rdata = 8'h00;
            end
         endcase
      end

      // Line driver, registered so the pins never glitch
      nxt_st.eye_phase = 1'b0;
      case (line_mode)
         USIE_LINE_PASS: begin
            nxt_st.dp = sie_tx_dp_i;
            nxt_st.dm = sie_tx_dm_i;
            nxt_st.oe = sie_tx_en_i;
         end
         USIE_LINE_RESUME: begin
            // K state is the inverse of idle J
            nxt_st.dp = ~j_dp;
            nxt_st.dm = j_dp;
            nxt_st.oe = 1'b1;
         end
         USIE_LINE_EYE: begin
            // Alternating J and K every bit time of this clock
            nxt_st.eye_phase = ~st_ff.eye_phase;
            nxt_st.dp = st_ff.eye_phase ? ~j_dp : j_dp;
            nxt_st.dm = st_ff.eye_phase ? j_dp : ~j_dp;
            nxt_st.oe = 1'b1;
         end
         default: begin
            // Undriven; the pull-up holds the line at J while attached
            nxt_st.dp = j_dp;
            nxt_st.dm = ~j_dp;
            nxt_st.oe = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_ff.ctrl      <= USIE_CTRL_RST;
         st_ff.cfg       <= USIE_CFG_RST;
         st_ff.dev_addr  <= USIE_DADDR_RST;
         st_ff.frame     <= USIE_FRAME_RST;
         st_ff.rdata     <= 8'h00;
         st_ff.ram_rd    <= 1'b0;
         st_ff.eye_phase <= 1'b0;
         st_ff.dp        <= 1'b0;
         st_ff.dm        <= 1'b0;
         st_ff.oe        <= 1'b0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign reg_rdata_o = st_ff.ram_rd ? ram_bus.cpu_rdata : st_ff.rdata;

   assign sie_addr_match_o = moden &&
                             (sie_tok_addr_i == st_ff.dev_addr);

   // Without ping-pong buffering the pointer reset has no effect
   assign pingpong_pointer_reset_o = st_ff.ctrl[USIE_CTRL_PPRST] &&
      (st_ff.cfg[USIE_CFG_PPM_HI:0] != USIE_PPM_NONE);

   // Completion events already queued are untouched by this flag;
   // it stops new packets on the engine side and keeps the line driver out of pass mode
   assign packet_transfer_disable_o = st_ff.ctrl[USIE_CTRL_PACKET_TRANSFER_DISABLE];

   assign suspend_request_o    = susp;
   assign sie_clk_enable_o     = moden && !susp;
   assign transceiver_enable_o = moden;
   assign full_speed_select_o  = fs;
   // Pull-up stays on in suspend so the device remains attached
   assign onchip_pullup_enable_o =
      st_ff.cfg[USIE_CFG_PULLUP] && moden;
   assign frame_valid_o        = moden && !susp;
   assign pingpong_mode_o      = st_ff.cfg[USIE_CFG_PPM_HI:0];

   assign usb_dp_o = st_ff.dp;
   assign usb_dm_o = st_ff.dm;
   assign usb_oe_o = st_ff.oe;
endmodule : usie_ctrl
`default_nettype wire

// *** verilog/usie_pkg.sv ***
// Constants and types for the bus interface engine control block
package usie_pkg;
   // Processor-side address map (12-bit data space)
   localparam logic [11:0] USIE_CTRL_ADDR  = 12'h060;
   localparam logic [11:0] USIE_CFG_ADDR   = 12'h061;
   localparam logic [11:0] USIE_DADDR_ADDR = 12'h062;
   localparam logic [11:0] USIE_FRML_ADDR  = 12'h063;
   localparam logic [11:0] USIE_FRMH_ADDR  = 12'h064;
   localparam logic [11:0] USIE_RAM_FIRST  = 12'h200;
   localparam logic [11:0] USIE_RAM_LAST   = 12'h2ff;
   // Last byte of the descriptor region, as a buffer-memory offset
   localparam logic [7:0]  USIE_DESC_LAST  = 8'h7f;

   // Control register fields
   localparam int USIE_CTRL_PPRST  = 6;
   localparam int USIE_CTRL_PACKET_TRANSFER_DISABLE = 4;
   localparam int USIE_CTRL_MODEN  = 3;
   localparam int USIE_CTRL_RESUME = 2;
   localparam int USIE_CTRL_SUSP   = 1;
   // Configuration register fields
   localparam int USIE_CFG_EYE     = 7;
   localparam int USIE_CFG_PULLUP  = 4;
   localparam int USIE_CFG_FS      = 2;
   localparam int USIE_CFG_PPM_HI  = 1;
   // Descriptor status byte: owner bit and packet-identifier field
   localparam int USIE_DESC_OWNER  = 7;
   localparam int USIE_DESC_PID_LO = 2;

   // Reset values
   localparam logic [7:0]  USIE_CTRL_RST  = 8'h00;
   localparam logic [7:0]  USIE_CFG_RST   = 8'h00;
   localparam logic [6:0]  USIE_DADDR_RST = 7'h00;
   localparam logic [10:0] USIE_FRAME_RST = 11'h000;
   localparam logic [1:0]  USIE_PPM_NONE  = 2'h0;
   // Writable bits; all others read back as zero
   localparam logic [7:0]  USIE_CTRL_WMASK = 8'h5e;
   localparam logic [7:0]  USIE_CFG_WMASK  = 8'h97;

   typedef enum logic [1:0] {
      USIE_LINE_PASS   = 2'b00,
      USIE_LINE_IDLE   = 2'b01,
      USIE_LINE_RESUME = 2'b10,
      USIE_LINE_EYE    = 2'b11
   } usie_line_e;
endpackage : usie_pkg

// *** verilog/usie_ram_if.sv ***
// Two-sided access path between the control block and the buffer memory
`timescale 1ns/1ps
`default_nettype none
interface usie_ram_if;
   logic       cpu_en;
   logic       cpu_we;
   logic [7:0] cpu_addr;
   logic [7:0] cpu_wdata;
   logic [7:0] cpu_rdata;
   logic       sie_en;
   logic       sie_we;
   logic [7:0] sie_addr;
   logic [7:0] sie_wdata;
   logic [7:0] sie_rdata;

   modport ctrl (output cpu_en, cpu_we, cpu_addr, cpu_wdata,
                 output sie_en, sie_we, sie_addr, sie_wdata,
                 input  cpu_rdata, sie_rdata);
   modport mem  (input  cpu_en, cpu_we, cpu_addr, cpu_wdata,
                 input  sie_en, sie_we, sie_addr, sie_wdata,
                 output cpu_rdata, sie_rdata);
endinterface : usie_ram_if
`default_nettype wire
